// file: aicr_pkg.sv
package aicr_pkg;
  // Register indices, not byte offsets; byte address is four times the index
  localparam logic [3:0] IDX_INPUT_SELECT = 4'h0;
  localparam logic [3:0] IDX_BIAS_ENABLE = 4'h1;
  localparam logic [3:0] IDX_REF_CAL = 4'h2;
  localparam logic [3:0] IDX_GAIN_RATE = 4'h3;
  localparam logic [3:0] IDX_OFFSET_LOW = 4'h4;
  localparam logic [3:0] IDX_OFFSET_MID = 4'h5;
  localparam logic [3:0] IDX_OFFSET_HIGH = 4'h6;
  localparam logic [3:0] IDX_FULLSCALE_LOW = 4'h7;
  localparam logic [3:0] IDX_FULLSCALE_MID = 4'h8;
  localparam logic [3:0] IDX_FULLSCALE_HIGH = 4'h9;
  localparam logic [3:0] IDX_REVISION = 4'hA;
  localparam logic [3:0] IDX_CURRENT_ROUTE = 4'hB;
  localparam logic [3:0] IDX_PIN_FUNCTION = 4'hC;
  localparam logic [3:0] IDX_PIN_DIRECTION = 4'hD;
  localparam logic [3:0] IDX_PIN_LEVEL = 4'hE;
  localparam int REG_COUNT = 15;
  // Reset values
  localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
  localparam logic [7:0] RST_BIAS_ENABLE = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FULLSCALE_HIGH = 8'h40;
  // Field positions
  localparam int BURNOUT_MSB = 7;
  localparam int BURNOUT_LSB = 6;
  localparam int POS_MSB = 5;
  localparam int POS_LSB = 3;
  localparam int NEG_MSB = 2;
  localparam int NEG_LSB = 0;
  localparam int REV_MSB = 7;
  localparam int REV_LSB = 4;
  localparam int READY_MODE_BIT = 3;
  localparam int CLKFLAG_BIT = 7;
  localparam int CAL_MSB = 2;
  localparam int CAL_LSB = 0;
  localparam int GAIN_MSB = 6;
  localparam int GAIN_LSB = 4;
  // Writable masks of mixed registers
  localparam logic [7:0] MASK_REVISION = 8'h08;
  localparam logic [7:0] MASK_REF_CAL = 8'h7F;
  localparam logic [7:0] MASK_GAIN_RATE = 8'h7F;
  // Calibration select codes forcing unity gain, and the unity gain code
  localparam logic [2:0] CAL_GAIN_CAL = 3'h2;
  localparam logic [2:0] CAL_TEMP = 3'h3;
  localparam logic [2:0] GAIN_UNITY = 3'h0;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : aicr_pkg

// file: aicr_input_config.sv
// Behaviour
// - Four-bit read-only revision code in upper bits
// - Bit 3 adds ready signal on serial output
// - Dedicated ready pin always signals ready low
// - Input select at 0x00, resets to 0x01
// - Calibration or bias overrides channel pair
// - Burnout current level field bits 7:6
// - Positive input code routes index to positive
// - Negative input code routes index to negative
// - Codes four to seven only on eight-input
// - Bias enables at 0x01, reset zero
// - Bias bit n biases analog input n
// - Four-input variant: upper bias bits zero
// - Eight-input variant: all bias bits writable
// - Calibration codes 010/011 force unity gain
module aicr_input_config #(
  parameter int INPUT_COUNT = 8,
  parameter logic [3:0] REVISION_CODE = 4'h5, // Arbitrary value
  parameter int HADDR_WIDTH = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic hsel,
  input wire logic [HADDR_WIDTH-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic clockSourceFlag,
  input wire logic conversionDone,
  input wire logic resultRead,
  input wire logic serialReadData,
  output logic serialOutReadyPin,
  output logic conversionReady_n,
  output logic [1:0] burnoutCurrentLevel,
  output logic [2:0] positiveInputCode,
  output logic [2:0] negativeInputCode,
  output logic channelPairOverridden,
  output logic [7:0] inputBiasEnables,
  output logic [2:0] calibrationInputSelect,
  output logic [2:0] amplifierGain,
  output logic readyOnOutputSelect
);
  // Bias bits that exist on this variant
  localparam logic [7:0] BIAS_MASK = (INPUT_COUNT >= 8) ? 8'hFF : 8'h0F;

  logic [7:0] regs [aicr_pkg::REG_COUNT];
  logic dataPending;
  logic wrPend;
  logic [3:0] wrIdx;
  logic [7:0] rdByte;
  logic [3:0] addrIdx;
  logic accept;
  logic [7:0] wrMask;

  assign addrIdx = haddr[HADDR_WIDTH-1:2];
  // Single-cycle slave, never waits, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = aicr_pkg::HRESP_OKAY;
  assign accept = hsel && hready && clockEnable &&
                  (htrans == aicr_pkg::HTRANS_NONSEQ || htrans == aicr_pkg::HTRANS_SEQ);

  // Address phase capture for writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      wrIdx <= 4'h0;
    end else if (clockEnable) begin
      wrPend <= accept && hwrite;
      wrIdx <= addrIdx;
    end
  end

  // Register storage, one loop per entry; read-only bits masked out
  genvar gi;
  generate
    for (gi = 0; gi < aicr_pkg::REG_COUNT; gi++) begin : gReg
      localparam logic [3:0] IDX = 4'(gi);
      localparam logic [7:0] RSTV =
        (IDX == aicr_pkg::IDX_INPUT_SELECT) ? aicr_pkg::RST_INPUT_SELECT :
        (IDX == aicr_pkg::IDX_BIAS_ENABLE) ? aicr_pkg::RST_BIAS_ENABLE :
        (IDX == aicr_pkg::IDX_FULLSCALE_HIGH) ? aicr_pkg::RST_FULLSCALE_HIGH :
        aicr_pkg::RST_ZERO;
      localparam logic [7:0] WMASK =
        (IDX == aicr_pkg::IDX_BIAS_ENABLE) ? BIAS_MASK :
        (IDX == aicr_pkg::IDX_REVISION) ? aicr_pkg::MASK_REVISION :
        (IDX == aicr_pkg::IDX_REF_CAL) ? aicr_pkg::MASK_REF_CAL :
        (IDX == aicr_pkg::IDX_GAIN_RATE) ? aicr_pkg::MASK_GAIN_RATE :
        8'hFF;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          regs[gi] <= RSTV;
        end else if (clockEnable && wrPend && wrIdx == IDX) begin
          regs[gi] <= hwdata[7:0] & WMASK;
        end
      end
    end
  endgenerate

  // Writable bits of the register whose write is in its data phase
  always_comb begin
    wrMask = 8'hFF;
    case (wrIdx)
      aicr_pkg::IDX_BIAS_ENABLE: wrMask = BIAS_MASK;
      aicr_pkg::IDX_REVISION: wrMask = aicr_pkg::MASK_REVISION;
      aicr_pkg::IDX_REF_CAL: wrMask = aicr_pkg::MASK_REF_CAL;
      aicr_pkg::IDX_GAIN_RATE: wrMask = aicr_pkg::MASK_GAIN_RATE;
      default: wrMask = 8'hFF;
    endcase
  end

  // Read mux inserts hardware-defined fields
  // A read right behind a write to the same register must see the new byte,
  // since storage only takes it at the edge that also latches the read
  always_comb begin
    rdByte = 8'h00;
    if (addrIdx < 4'(aicr_pkg::REG_COUNT)) begin
      rdByte = regs[addrIdx];
      if (wrPend && wrIdx == addrIdx) begin
        rdByte = hwdata[7:0] & wrMask;
      end
    end
    if (addrIdx == aicr_pkg::IDX_REVISION) begin
      rdByte[aicr_pkg::REV_MSB:aicr_pkg::REV_LSB] = REVISION_CODE;
    end
    if (addrIdx == aicr_pkg::IDX_REF_CAL) begin
      rdByte[aicr_pkg::CLKFLAG_BIT] = clockSourceFlag;
    end
  end

  // Read data registered in data phase; unmapped reads return zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (clockEnable && accept && !hwrite) begin
      hrdata <= {24'h00_0000, rdByte};
    end
  end

  // Ready flag: new result sets, read clears; set wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dataPending <= 1'b0;
    end else if (clockEnable) begin
      if (conversionDone) begin
        dataPending <= 1'b1;
      end else if (resultRead) begin
        dataPending <= 1'b0;
      end
    end
  end

  // Pin outputs registered to keep them glitch free
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conversionReady_n <= 1'b1;
      serialOutReadyPin <= 1'b1;
    end else if (clockEnable) begin
      conversionReady_n <= !dataPending;
      // Host must keep mode clear in stopped read mode; not checked here
      if (regs[aicr_pkg::IDX_REVISION][aicr_pkg::READY_MODE_BIT] && !resultRead) begin
        serialOutReadyPin <= !dataPending;
      end else begin
        serialOutReadyPin <= serialReadData;
      end
    end
  end

  // Control outputs decoded from storage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      burnoutCurrentLevel <= 2'h0;
      positiveInputCode <= 3'h0;
      negativeInputCode <= 3'h1;
      channelPairOverridden <= 1'b0;
      inputBiasEnables <= 8'h00;
      calibrationInputSelect <= 3'h0;
      amplifierGain <= 3'h0;
      readyOnOutputSelect <= 1'b0;
    end else if (clockEnable) begin
      burnoutCurrentLevel <= regs[aicr_pkg::IDX_INPUT_SELECT]
        [aicr_pkg::BURNOUT_MSB:aicr_pkg::BURNOUT_LSB];
      // Four-input variant keeps only the low two code bits
      positiveInputCode <= regs[aicr_pkg::IDX_INPUT_SELECT]
        [aicr_pkg::POS_MSB:aicr_pkg::POS_LSB] & ((INPUT_COUNT >= 8) ? 3'h7 : 3'h3);
      negativeInputCode <= regs[aicr_pkg::IDX_INPUT_SELECT]
        [aicr_pkg::NEG_MSB:aicr_pkg::NEG_LSB] & ((INPUT_COUNT >= 8) ? 3'h7 : 3'h3);
      channelPairOverridden <= (regs[aicr_pkg::IDX_REF_CAL][aicr_pkg::CAL_MSB:aicr_pkg::CAL_LSB]
        != 3'h0) || (regs[aicr_pkg::IDX_BIAS_ENABLE] != 8'h00);
      inputBiasEnables <= regs[aicr_pkg::IDX_BIAS_ENABLE] & BIAS_MASK;
      calibrationInputSelect <= regs[aicr_pkg::IDX_REF_CAL][aicr_pkg::CAL_MSB:aicr_pkg::CAL_LSB];
      if (regs[aicr_pkg::IDX_REF_CAL][aicr_pkg::CAL_MSB:aicr_pkg::CAL_LSB] == aicr_pkg::CAL_GAIN_CAL ||
          regs[aicr_pkg::IDX_REF_CAL][aicr_pkg::CAL_MSB:aicr_pkg::CAL_LSB] == aicr_pkg::CAL_TEMP) begin
        amplifierGain <= aicr_pkg::GAIN_UNITY;
      end else begin
        amplifierGain <= regs[aicr_pkg::IDX_GAIN_RATE][aicr_pkg::GAIN_MSB:aicr_pkg::GAIN_LSB];
      end
      readyOnOutputSelect <= regs[aicr_pkg::IDX_REVISION][aicr_pkg::READY_MODE_BIT];
    end
  end
endmodule : aicr_input_config

// file: aicr_input_config_sva.sv
module aicr_input_config_sva #(
  parameter int INPUT_COUNT = 8,
  parameter logic [3:0] REVISION_CODE = 4'h5,
  parameter int HADDR_WIDTH = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic hsel,
  input wire logic [HADDR_WIDTH-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic conversionDone,
  input wire logic conversionReady_n,
  input wire logic [1:0] burnoutCurrentLevel,
  input wire logic [2:0] positiveInputCode,
  input wire logic [2:0] negativeInputCode,
  input wire logic channelPairOverridden,
  input wire logic [7:0] inputBiasEnables,
  input wire logic [2:0] calibrationInputSelect,
  input wire logic [2:0] amplifierGain,
  input wire logic readyOnOutputSelect
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Write byte, delayed in the properties to its data phase
  logic [7:0] wd;
  assign wd = hwdata[7:0];
  // Address phase taken, then the write landing at the outputs two edges on
  sequence acc(logic w, logic [3:0] i);
    hsel && hready && htrans[1] && hwrite == w && clockEnable && haddr[5:2] == i;
  endsequence
  sequence lands(logic [3:0] i);
    acc(1'b1, i) ##1 clockEnable [*3];
  endsequence
  a_rev_read: assert property (
    acc(1'b0, 4'hA) |=> hrdata[7:4] == REVISION_CODE && hrdata[2:0] == 3'h0)
    else $error("Bad revision read");
  a_sel_follow: assert property (
    lands(4'h0) |-> {burnoutCurrentLevel, positiveInputCode, negativeInputCode} == $past(wd, 2))
    else $error("Input select outputs wrong");
  a_bias_follow: assert property (
    lands(4'h1) |-> inputBiasEnables == $past(wd, 2))
    else $error("Bias outputs wrong");
  a_mode_follow: assert property (
    lands(4'hA) |-> {4'h0, readyOnOutputSelect, 3'h0} == ($past(wd, 2) & 8'h08))
    else $error("Ready mode output wrong");
  a_ready_low: assert property (
    conversionDone && clockEnable ##1 clockEnable |=> !conversionReady_n)
    else $error("Ready pin not low");
  a_pair_override: assert property (
    channelPairOverridden == (|inputBiasEnables || calibrationInputSelect != 3'h0))
    else $error("Override flag wrong");
  a_unity_gain: assert property (
    calibrationInputSelect inside {3'h2, 3'h3} |-> amplifierGain == 3'h0)
    else $error("Gain not forced to one");
  a_reset_pair: assert property (
    $rose(rst_n) |-> positiveInputCode == 3'h0 && negativeInputCode == 3'h1)
    else $error("Reset channel pair wrong");
endmodule : aicr_input_config_sva
bind aicr_input_config aicr_input_config_sva #(.INPUT_COUNT(INPUT_COUNT),
  .REVISION_CODE(REVISION_CODE), .HADDR_WIDTH(HADDR_WIDTH)) chk_u (.clock, .rst_n,
  .clockEnable, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .conversionDone,
  .conversionReady_n, .burnoutCurrentLevel, .positiveInputCode, .negativeInputCode,
  .channelPairOverridden, .inputBiasEnables, .calibrationInputSelect, .amplifierGain,
  .readyOnOutputSelect);

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] REV = 4'hC; // Arbitrary value
  logic clock = 1'b0, rst_n = 1'b0, clockEnable = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic hready, clockSourceFlag = 1'b0, conversionDone = 1'b0, resultRead = 1'b0;
  logic serialReadData = 1'b0, hreadyout, hresp, serialOutReadyPin, conversionReady_n;
  logic channelPairOverridden, readyOnOutputSelect;
  logic [5:0] haddr = 6'h00;
  logic [1:0] htrans = 2'h0, burnoutCurrentLevel;
  logic [2:0] hsize = 3'h2, positiveInputCode, negativeInputCode;
  logic [2:0] calibrationInputSelect, amplifierGain;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [7:0] inputBiasEnables, wd, mir [16];
  logic [3:0] idx;
  logic [11:0] corner [8] = '{12'h3F5, 12'h282, 12'h203, 12'h201, 12'hAF8, 12'h1FF, 12'h0FF,
    12'hFAA};
  int mismatches = 0, cmp_count = 0;
  aicr_input_config #(.REVISION_CODE(REV)) dut_u (.clock, .rst_n, .clockEnable, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .clockSourceFlag,
    .conversionDone, .resultRead, .serialReadData, .serialOutReadyPin, .conversionReady_n,
    .burnoutCurrentLevel, .positiveInputCode, .negativeInputCode, .channelPairOverridden,
    .inputBiasEnables, .calibrationInputSelect, .amplifierGain, .readyOnOutputSelect);
  // One slave on the bus, so its ready is the bus ready
  assign hready = hreadyout;
  initial forever #25 clock = ~clock;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Single transfer; waits on hreadyout rather than assuming zero wait
  task automatic xfer(input logic [3:0] i, input logic w, input logic [7:0] d);
    htrans <= aicr_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {i, 2'h0};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  // Writable bits; read-only ones stay zero in the mirror
  function automatic logic [7:0] wmask(input logic [3:0] i);
    case (i)
      4'h2, 4'h3: return 8'h7F;
      4'hA: return 8'h08;
      4'hF: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction : wmask
  function automatic logic [31:0] expRd(input logic [3:0] i);
    return {24'h0, mir[i] | (i == 4'hA ? {REV, 4'h0} : 8'h00) | (i == 4'h2 ? {clockSourceFlag, 7'h0} : 8'h00)};
  endfunction : expRd
  // Every control output against the mirror; calibration codes 2 and 3 force gain
  task automatic chkOut();
    check({channelPairOverridden, readyOnOutputSelect, amplifierGain, calibrationInputSelect,
      inputBiasEnables, burnoutCurrentLevel, positiveInputCode, negativeInputCode},
      {(|mir[1]) || mir[2][2:0] != 3'h0, mir[10][3], mir[2][2:1] == 2'h1 ? 3'h0 : mir[3][6:4],
      mir[2][2:0], mir[1], mir[0]});
    // No result pending here: combined mode shows idle high, plain mode the data
    check({hreadyout, hresp, serialOutReadyPin, conversionReady_n},
      {1'b1, aicr_pkg::HRESP_OKAY, mir[10][3] | serialReadData, 1'b1});
  endtask : chkOut
  // Hang guard, far beyond the roughly 400 cycles the sequence needs
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    mir = '{default: 8'h00};
    mir[0] = 8'h01;
    mir[9] = 8'h40;
    void'($urandom(32'h676A));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 16; i++) begin
      xfer(4'(i), 1'b0, 8'h00);
      check(rd, expRd(4'(i)));
    end
    chkOut();
    // Corner writes first, then random ones, each read back
    for (int n = 0; n < 48; n++) begin
      {idx, wd} = n < 8 ? corner[n] : {4'($urandom_range(0, 15)), 8'($urandom)};
      if (idx == 4'hA) wd[2:0] = 3'h0;
      clockSourceFlag <= 1'($urandom);
      serialReadData <= 1'($urandom);
      xfer(idx, 1'b1, wd);
      mir[idx] = wd & wmask(idx);
      repeat (2) @(posedge clock);
      #1 chkOut();
      @(posedge clock);
      xfer(idx, 1'b0, 8'h00);
      check(rd, expRd(idx));
    end
    // Frozen clock enable drops the write
    clockEnable <= 1'b0;
    xfer(4'h0, 1'b1, 8'hFF);
    clockEnable <= 1'b1;
    xfer(4'h0, 1'b0, 8'h00);
    check(rd, expRd(4'h0));
    // Ready shown on both pins in combined mode, then cleared by the read
    xfer(4'hA, 1'b1, 8'h08);
    conversionDone <= 1'b1;
    @(posedge clock);
    conversionDone <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check({serialOutReadyPin, conversionReady_n}, 2'h0);
    @(posedge clock);
    resultRead <= 1'b1;
    @(posedge clock);
    resultRead <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check({serialOutReadyPin, conversionReady_n}, 2'h3);
    summarize();
  end
endmodule : tb_top
